// ### hw/nv_store_pkg.sv
`default_nettype none
package nv_store_pkg;
    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_PROTECT_KEY = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_0 = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_1 = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_TARGET_LOC = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_WRITE_BYTE = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLES = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h01C;
    // Stored bytes appear as a 256-byte window, two bytes per word.
    localparam logic [ADDR_W-1:0] EEPROM_BASE = 12'h100;
    localparam logic [3:0] EEPROM_PAGE = 4'h1;

    // ---------------------------------------------------------------
    // Field positions and values
    // ---------------------------------------------------------------
    localparam logic [15:0] UNLOCK_KEY = 16'h0096;
    localparam int BIT_REPROGRAM_MODE = 0;
    localparam int BIT_SUPPLY_ON = 1;
    localparam int BIT_STROBE = 0;
    localparam int BIT_ACCESS_DONE = 0;
    localparam int BIT_ECC_FIXED = 1;
    localparam int BIT_BUSY = 0;
    localparam int BIT_UNLOCKED = 1;
    localparam int NUM_FLAGS = 2;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] RST_PROTECT_KEY = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_FLAGS = 2'h0;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_TIME_NS = 100000;
    // Least time: round up to whole cycles.
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W = 12;
endpackage
`default_nettype wire

// ### hw/nv_array_if.sv
`default_nettype none
interface nv_array_if;
    logic prog_en;
    logic [7:0] prog_addr;
    logic [7:0] prog_data;
    logic [7:0] prog_fault;
    logic [7:0] rd_addr;
    logic [15:0] rd_data;
    logic [1:0] rd_fixed;
    modport ctrl(output prog_en, prog_addr, prog_data, prog_fault, rd_addr, input rd_data, rd_fixed);
    modport store(input prog_en, prog_addr, prog_data, prog_fault, rd_addr, output rd_data, rd_fixed);
endinterface
`default_nettype wire

// ### hw/nv_cell_array.sv
`default_nettype none
module nv_cell_array (
    input wire logic core_clk_in,
    nv_array_if.store arr
);
    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    // Three copies per byte; a majority vote stands in for the error
    // correction. Contents are nonvolatile, so no reset is applied.
    logic [7:0] copy_a [256];
    logic [7:0] copy_b [256];
    logic [7:0] copy_c [256];

    // A worn cell is modelled by flipping bits of one copy on program.
    always_ff @(posedge core_clk_in) begin
        if (arr.prog_en) begin
            copy_a[arr.prog_addr] <= arr.prog_data ^ arr.prog_fault;
            copy_b[arr.prog_addr] <= arr.prog_data;
            copy_c[arr.prog_addr] <= arr.prog_data;
        end
    end

    // Two bytes at an even location, voted and flagged when corrected.
    always_comb begin
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        a = 8'h00;
        b = 8'h00;
        c = 8'h00;
        arr.rd_data = 16'h0000;
        arr.rd_fixed = 2'h0;
        for (int i = 0; i < 2; i++) begin
            a = copy_a[{arr.rd_addr[7:1], i[0]}];
            b = copy_b[{arr.rd_addr[7:1], i[0]}];
            c = copy_c[{arr.rd_addr[7:1], i[0]}];
            arr.rd_data[i*8 +: 8] = (a & b) | (a & c) | (b & c);
            arr.rd_fixed[i] = (a != b) || (a != c);
        end
    end
endmodule
`default_nettype wire

// ### hw/nv_program_timer.sv
`default_nettype none
module nv_program_timer
    import nv_store_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    logic [PROG_CNT_W-1:0] count_r;

    // ---------------------------------------------------------------
    // Programming interval
    // ---------------------------------------------------------------
    // Loads on start, counts down, and pulses done in the cycle after the last, as busy falls.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                count_r <= PROG_CNT_W'(PROG_CYCLES - 1);
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (count_r == '0) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    count_r <= count_r - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### hw/nv_byte_store_controller.sv
// Contract
// R01: Software writes the unlock key to the protect key field before reprogramming.
// R02: Software sets mode and supply bits, then waits for the supply to settle.
// R03: Device holds an 8-bit target location loaded by software per byte.
// R04: Device holds an 8-bit write byte; software keeps a copy for verifying.
// R05: Writing 1 to the strobe emits a pulse that programs the loaded byte.
// R06: Device sets the done flag when programming a byte finishes.
// R07: Software repeats clear, enable, load, load, strobe, wait for each byte.
// R08: After the last byte, software clears the mode and supply bits.
// R09: Writing any non-key value to the key field restores protection.
// R10: Software reads back and compares the programmed bytes at the end.
// R11: Ordinary reads in the window return the stored bytes.
// R12: A 32-bit read carries only 16 stored bits; upper bits are zero.
// R13: Reads made in reprogramming mode are undefined and must not be relied on.
// R14: The done flag is also set when a stored-byte read completes; write 1 clears.
// R15: A corrected read sets the ECC flag; writing 1 clears it.
// R16: Interrupt requested only while a flag is set and its enable is 1.
// R17: After an ECC event software relocates data and retires that location.
// R18: Strobe self-clears; a strobe without mode and supply changes no contents.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`default_nettype none
module nv_byte_store_controller
    import nv_store_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    // AXI4-Lite slave.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Bits of one copy that are corrupted when a byte is programmed.
    input wire logic [7:0] wear_fault_in,
    output logic program_pulse_out,
    output logic program_busy_out,
    output logic irq_out
);
    // ---------------------------------------------------------------
    // Registers and internal signals
    // ---------------------------------------------------------------
    logic [15:0] protect_key_r;
    logic reprogram_mode_on_r;
    logic program_supply_on_r;
    logic [7:0] target_location_r;
    logic [7:0] write_byte_r;
    logic [1:0] irq_flags_r;
    logic [1:0] irq_enables_r;
    logic program_strobe_r;
    logic [7:0] prog_addr_r;
    logic [7:0] prog_data_r;
    logic [7:0] prog_fault_r;

    logic [ADDR_W-1:0] aw_addr_r;
    logic aw_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_held_r;
    logic do_write;
    logic wr_mapped;
    logic rd_take;
    logic rd_is_eeprom;
    logic rd_mapped;
    logic [31:0] rd_word;
    logic unlocked;
    logic strobe_write;
    logic prog_start;
    logic prog_done;
    logic prog_busy;
    logic eeprom_read_done;
    logic ecc_event;
    logic flags_read;
    logic [1:0] flags_w1c;
    logic [15:0] key_merged;

    nv_array_if arr_if ();

    // ---------------------------------------------------------------
    // Submodules
    // ---------------------------------------------------------------
    nv_cell_array u_cells (
        .core_clk_in(core_clk_in),
        .arr(arr_if.store)
    );

    nv_program_timer u_timer (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(prog_start),
        .busy_out(prog_busy),
        .done_out(prog_done)
    );

    // ---------------------------------------------------------------
    // Write channel
    // ---------------------------------------------------------------
    // Address and data are caught independently and the write is done
    // once both are held and no response is still waiting.
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    // Only the control registers answer a write; the stored-byte window
    // is read-only from the bus, since bytes change only by programming.
    always_comb begin
        case ({aw_addr_r[ADDR_W-1:2], 2'b00})
            OFS_PROTECT_KEY, OFS_CONTROL_0, OFS_CONTROL_1, OFS_TARGET_LOC,
            OFS_WRITE_BYTE, OFS_IRQ_FLAGS, OFS_IRQ_ENABLES: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Protection key
    // ---------------------------------------------------------------
    assign key_merged = {w_strb_r[1] ? w_data_r[15:8] : protect_key_r[15:8],
                         w_strb_r[0] ? w_data_r[7:0] : protect_key_r[7:0]};
    // R01: unlock key check
    assign unlocked = (protect_key_r == UNLOCK_KEY);

    // R09: any other value relocks
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            protect_key_r <= RST_PROTECT_KEY;
        end else if (do_write && aw_addr_r == OFS_PROTECT_KEY) begin
            protect_key_r <= key_merged;
        end
    end

    // ---------------------------------------------------------------
    // Protected control registers and interrupt enables
    // ---------------------------------------------------------------
    // Writes while locked complete with OKAY; all but the interrupt enables
    // keep their value, so a stray store cannot start programming.
    // R02: mode and supply bits
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reprogram_mode_on_r <= 1'b0;
            program_supply_on_r <= 1'b0;
        end else if (do_write && unlocked && aw_addr_r == OFS_CONTROL_0 && w_strb_r[0]) begin
            reprogram_mode_on_r <= w_data_r[BIT_REPROGRAM_MODE];
            program_supply_on_r <= w_data_r[BIT_SUPPLY_ON];
        end
    end

    // R03: target location field
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            target_location_r <= RST_BYTE;
        end else if (do_write && unlocked && aw_addr_r == OFS_TARGET_LOC && w_strb_r[0]) begin
            target_location_r <= w_data_r[7:0];
        end
    end

    // R04: write byte field
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            write_byte_r <= RST_BYTE;
        end else if (do_write && unlocked && aw_addr_r == OFS_WRITE_BYTE && w_strb_r[0]) begin
            write_byte_r <= w_data_r[7:0];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_enables_r <= RST_FLAGS;
        end else if (do_write && aw_addr_r == OFS_IRQ_ENABLES && w_strb_r[0]) begin
            irq_enables_r <= w_data_r[NUM_FLAGS-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Program strobe
    // ---------------------------------------------------------------
    assign strobe_write = do_write && unlocked && aw_addr_r == OFS_CONTROL_1 && w_strb_r[0]
                          && w_data_r[BIT_STROBE];
    // R18: gate by mode and supply
    assign prog_start = program_strobe_r && reprogram_mode_on_r && program_supply_on_r && !prog_busy;

    // R18: strobe self-clears
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            program_strobe_r <= 1'b0;
        end else begin
            program_strobe_r <= strobe_write;
        end
    end

    // R05: pulse latches the operands
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            program_pulse_out <= 1'b0;
            prog_addr_r <= RST_BYTE;
            prog_data_r <= RST_BYTE;
            prog_fault_r <= RST_BYTE;
        end else begin
            program_pulse_out <= prog_start;
            if (prog_start) begin
                prog_addr_r <= target_location_r;
                prog_data_r <= write_byte_r;
                prog_fault_r <= wear_fault_in;
            end
        end
    end

    // The cells take the byte when the programming interval ends.
    assign arr_if.prog_en = prog_done;
    assign arr_if.prog_addr = prog_addr_r;
    assign arr_if.prog_data = prog_data_r;
    assign arr_if.prog_fault = prog_fault_r;
    assign program_busy_out = prog_busy;

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_is_eeprom = (s_axi_araddr[ADDR_W-1:8] == EEPROM_PAGE);
    assign arr_if.rd_addr = s_axi_araddr[7:0];

    // R11: stored bytes in the window
    // R12: upper half reads zero
    // R13: mode reads give zero
    always_comb begin
        rd_word = 32'h00000000;
        rd_mapped = 1'b1;
        if (rd_is_eeprom) begin
            if (!reprogram_mode_on_r) begin
                rd_word = {16'h0000, arr_if.rd_data};
            end
        end else begin
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                OFS_PROTECT_KEY: rd_word = {16'h0000, protect_key_r};
                OFS_CONTROL_0: rd_word = {30'h00000000, program_supply_on_r, reprogram_mode_on_r};
                OFS_CONTROL_1: rd_word = 32'h00000000;
                OFS_TARGET_LOC: rd_word = {24'h000000, target_location_r};
                OFS_WRITE_BYTE: rd_word = {24'h000000, write_byte_r};
                OFS_IRQ_FLAGS: rd_word = {30'h00000000, irq_flags_r};
                OFS_IRQ_ENABLES: rd_word = {30'h00000000, irq_enables_r};
                OFS_STATUS: rd_word = {30'h00000000, unlocked, prog_busy};
                default: rd_mapped = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt flags
    // ---------------------------------------------------------------
    // R14: read completion event
    assign eeprom_read_done = rd_take && rd_is_eeprom && !reprogram_mode_on_r;
    // R15: corrected read event
    assign ecc_event = eeprom_read_done && (arr_if.rd_fixed != 2'h0);
    assign flags_read = rd_take && s_axi_araddr[ADDR_W-1:2] == OFS_IRQ_FLAGS[ADDR_W-1:2];
    assign flags_w1c = (do_write && aw_addr_r == OFS_IRQ_FLAGS && w_strb_r[0]) ?
                       w_data_r[NUM_FLAGS-1:0] : 2'h0;

    // Clears by write-one or by reading the flags; a new event in the
    // same cycle wins so no completion is lost.
    // R06: done flag set
    // R14: write one clears
    // R15: write one clears
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_flags_r <= RST_FLAGS;
        end else begin
            for (int i = 0; i < NUM_FLAGS; i++) begin
                if (flags_read || flags_w1c[i]) begin
                    irq_flags_r[i] <= 1'b0;
                end
            end
            if (prog_done || eeprom_read_done) begin
                irq_flags_r[BIT_ACCESS_DONE] <= 1'b1;
            end
            if (ecc_event) begin
                irq_flags_r[BIT_ECC_FIXED] <= 1'b1;
            end
        end
    end

    // R16: flag and enable
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_flags_r & irq_enables_r);
        end
    end
endmodule
`default_nettype wire

// ### sim/nv_store_sva.sv
`default_nettype none
// ----------------------------------------
// Port checks for the byte store block.
// ----------------------------------------
module nv_store_sva
    import nv_store_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic program_pulse_out,
    input wire logic program_busy_out,
    input wire logic irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    int busy_cnt_r;
    // Busy stretch length, so the program time can be judged where busy ends.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= program_busy_out ? busy_cnt_r + 1 : 0;
        end
    end
    property p_pulse_one; program_pulse_out |=> !program_pulse_out; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("program pulse longer than one cycle");
    property p_busy_min; program_pulse_out |=> program_busy_out [*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy did not follow the pulse");
    property p_busy_cause; $rose(program_busy_out) |-> program_pulse_out || $past(program_pulse_out); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy rose without a pulse");
    property p_busy_len; $fell(program_busy_out) |-> busy_cnt_r >= PROG_CYCLES - 1 && busy_cnt_r <= PROG_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("program interval has the wrong length");
    property p_pulse_idle; program_pulse_out |-> !$past(program_busy_out); endproperty
    a_pulse_idle: assert property (p_pulse_idle) else $error("pulse while still busy");
    property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper half not zero");
    property p_ar_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ar_lat: assert property (p_ar_lat) else $error("read answer late");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while response pending");
    c_prog: cover property (program_pulse_out);
    c_irq: cover property ($rose(irq_out));
    c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind nv_byte_store_controller nv_store_sva u_sva (.*);
`default_nettype wire

// ### sim/nv_byte_store_controller_tb_top.sv
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module nv_byte_store_controller_tb_top
    import nv_store_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] wear_fault_in = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_v;
    logic [31:0] s_axi_rdata, rd_v;
    logic program_pulse_out, program_busy_out, irq_out;
    int n_errors = 0, tests_run = 0, pulses = 0;

    nv_byte_store_controller uut (.*);

    // Free running clock, 40 ns period.
    always #20 core_clk_in = ~core_clk_in;

    // Pulses are counted so that refused strobes show up as a missing count.
    always @(posedge core_clk_in) begin
        if (program_pulse_out === 1'h1) begin
            pulses <= pulses + 1;
        end
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Each valid is dropped only at the edge where its ready was seen high.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk_in);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        resp_v = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] ex, input logic [1:0] er);
        @(posedge core_clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk_in);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd_v = s_axi_rdata;
        resp_v = s_axi_rresp;
        s_axi_rready <= 1'h0;
        `CHK("rdata", ex, rd_v);
        `CHK("rresp", er, resp_v);
    endtask

    // One whole byte: clear, enable, load, load, strobe, await completion.
    task automatic prog(input logic [7:0] a, input logic [7:0] d);
        int n;
        wr(OFS_IRQ_FLAGS, 32'h1);
        wr(OFS_IRQ_ENABLES, 32'h1);
        wr(OFS_TARGET_LOC, {24'h0, a});
        wr(OFS_WRITE_BYTE, {24'h0, d});
        wr(OFS_CONTROL_1, 32'h1);
        n = 0;
        while (irq_out !== 1'h1 && n < 4000) begin
            @(posedge core_clk_in);
            n++;
        end
        `CHK("irq_done", 1'h1, irq_out);
        rchk(OFS_IRQ_FLAGS, 32'h1, RESP_OKAY);
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'h0;
        rchk(OFS_PROTECT_KEY, {16'h0, RST_PROTECT_KEY}, RESP_OKAY);
        rchk(12'h020, 32'h0, RESP_SLVERR);
        wr(OFS_TARGET_LOC, 32'h55);
        rchk(OFS_TARGET_LOC, {24'h0, RST_BYTE}, RESP_OKAY);
        wr(OFS_PROTECT_KEY, {16'h0, UNLOCK_KEY});
        rchk(OFS_STATUS, 32'h2, RESP_OKAY);
        wr(OFS_CONTROL_1, 32'h1);
        repeat (4) @(posedge core_clk_in);
        `CHK("pulses", 0, pulses);
        wr(OFS_CONTROL_0, 32'h3);
        rchk(OFS_CONTROL_0, 32'h3, RESP_OKAY);
        prog(8'h10, 8'hA5);
        prog(8'h11, 8'h3C);
        rchk(OFS_TARGET_LOC, 32'h11, RESP_OKAY);
        rchk(OFS_WRITE_BYTE, 32'h3C, RESP_OKAY);
        // One corrupted copy, so the later read must be corrected.
        wear_fault_in <= 8'hFF;
        prog(8'h20, 8'h5A);
        wear_fault_in <= 8'h00;
        prog(8'h21, 8'hC3);
        `CHK("pulses", 4, pulses);
        wr(OFS_CONTROL_0, 32'h0);
        wr(OFS_PROTECT_KEY, 32'h1);
        rchk(OFS_STATUS, 32'h0, RESP_OKAY);
        wr(OFS_TARGET_LOC, 32'h77);
        rchk(OFS_TARGET_LOC, 32'h21, RESP_OKAY);
        wr(OFS_CONTROL_1, 32'h1);
        repeat (4) @(posedge core_clk_in);
        `CHK("pulses", 4, pulses);
        wr(OFS_IRQ_ENABLES, 32'h0);
        wr(OFS_IRQ_FLAGS, 32'h3);
        rchk(EEPROM_BASE + 12'h010, 32'h3CA5, RESP_OKAY);
        // The flag set by the read reaches the interrupt a cycle later.
        repeat (2) @(posedge core_clk_in);
        `CHK("irq_masked", 1'h0, irq_out);
        rchk(OFS_IRQ_FLAGS, 32'h1, RESP_OKAY);
        wr(OFS_IRQ_ENABLES, 32'h2);
        rchk(EEPROM_BASE + 12'h020, 32'hC35A, RESP_OKAY);
        repeat (2) @(posedge core_clk_in);
        `CHK("irq_ecc", 1'h1, irq_out);
        wr(OFS_IRQ_FLAGS, 32'h3);
        repeat (2) @(posedge core_clk_in);
        `CHK("irq_clear", 1'h0, irq_out);
        // The corrected pair moves to fresh locations; the worn one is not reused.
        wr(OFS_PROTECT_KEY, {16'h0, UNLOCK_KEY});
        wr(OFS_CONTROL_0, 32'h3);
        prog(8'h30, 8'h5A);
        prog(8'h31, 8'hC3);
        wr(OFS_CONTROL_0, 32'h0);
        wr(OFS_PROTECT_KEY, 32'h0);
        rchk(EEPROM_BASE + 12'h030, 32'hC35A, RESP_OKAY);
        rchk(OFS_IRQ_FLAGS, 32'h1, RESP_OKAY);
        wr(EEPROM_BASE, 32'h0);
        `CHK("win_wr", RESP_SLVERR, resp_v);
        summarize();
    end

    // Six program intervals plus bus traffic fit well inside this span.
    initial begin
        repeat (30000) @(posedge core_clk_in);
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
